// [design/tlic_pick.sv]
// fixed-order poll picker: high level beats low, lowest index wins
// assumes: candidates are already masked by enables and in-service level
`timescale 1ns/10ps
module tlic_pick (
	tlic_pick_if.pick port
);

	// ==========================================================
	// lowest set index
	function automatic logic [3:0] first_idx(
		input logic [tlic_pkg::NSRC-1:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = tlic_pkg::NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	wire any_hi = |port.cand_hi;
	wire any_lo = |port.cand_lo;

	assign port.found = any_hi | any_lo;
	assign port.hi    = any_hi;
	assign port.idx   = any_hi ? first_idx(port.cand_hi)
	                           : first_idx(port.cand_lo);

endmodule

// [design/tlic_pick_if.sv]
// candidates and winner between the controller and its poll picker
// assumes: both ends run on the same clock, the picker is combinational
`timescale 1ns/10ps
interface tlic_pick_if;
	logic [tlic_pkg::NSRC-1:0] cand_hi;
	logic [tlic_pkg::NSRC-1:0] cand_lo;
	logic                      found;
	logic                      hi;
	logic [3:0]                idx;

	modport ctrl (output cand_hi, output cand_lo,
		input found, input hi, input idx);
	modport pick (input cand_hi, input cand_lo,
		output found, output hi, output idx);
endinterface

// [design/tlic_pkg.sv]
// constants, field positions and types of the two-level interrupt controller
// assumes: an 8051-style core on the same clock owns the special-function bus
package tlic_pkg;

	localparam int NSRC  = 11;
	localparam int NSTAT = 4;

	// ==========================================================
	// register offsets
	localparam logic [7:0] ADDR_IE    = 8'hA8;
	localparam logic [7:0] ADDR_SECONDARY_ENABLE_PRIORITY = 8'hA9;
	localparam logic [7:0] ADDR_IP    = 8'hB8;
	localparam logic [7:0] ADDR_STAT  = 8'hE8;
	localparam logic [7:0] ADDR_MASK  = 8'hE9;
	localparam logic [7:0] ADDR_SVC   = 8'hEA;

	// ==========================================================
	// reset values and writable bits
	localparam logic [7:0] RST_IE     = 8'h00;
	localparam logic [7:0] RST_IP     = 8'h00;
	localparam logic [7:0] RST_SECONDARY_ENABLE_PRIORITY  = 8'hA0;
	localparam logic [3:0] RST_STAT   = 4'h0;
	localparam logic [3:0] RST_MASK   = 4'h0;
	localparam logic [7:0] WMASK_IP   = 8'h7F;
	localparam logic [7:0] WMASK_IE2  = 8'h77;

	// ==========================================================
	// field positions
	localparam logic [2:0] IE_GLOBAL  = 3'h7;
	localparam logic [2:0] IE_ADC     = 3'h6;
	localparam logic [2:0] IE_T2      = 3'h5;
	localparam logic [2:0] IE_UART    = 3'h4;
	localparam logic [2:0] IE_T1      = 3'h3;
	localparam logic [2:0] IE_EXT1    = 3'h2;
	localparam logic [2:0] IE_T0      = 3'h1;
	localparam logic [2:0] IE_EXT0    = 3'h0;
	localparam logic [2:0] E2_TIC_PRI = 3'h6;
	localparam logic [2:0] E2_PSM_PRI = 3'h5;
	localparam logic [2:0] E2_SPI_PRI = 3'h4;
	localparam logic [2:0] E2_TIC_EN  = 3'h2;
	localparam logic [2:0] E2_PSM_EN  = 3'h1;
	localparam logic [2:0] E2_SPI_EN  = 3'h0;
	localparam logic [1:0] ST_TAKEN   = 2'h0;
	localparam logic [1:0] ST_PREEMPT = 2'h1;
	localparam logic [1:0] ST_WDT_IRQ = 2'h2;
	localparam logic [1:0] ST_WDT_RST = 2'h3;

	// ==========================================================
	// sources in polling order, index 0 polled first
	localparam logic [3:0] SRC_WDT = 4'h1;
	localparam logic [15:0] VEC [NSRC] = '{16'h0043, 16'h005B, 16'h0003,
		16'h0033, 16'h000B, 16'h0013, 16'h001B, 16'h003B, 16'h0023,
		16'h002B, 16'h0053};

	typedef enum logic [3:0] {
		SVC_NONE  = 4'b0001,
		SVC_LO    = 4'b0010,
		SVC_HI    = 4'b0100,
		SVC_LO_HI = 4'b1000
	} tlic_svc_e;

endpackage

// [design/tlic_top.sv]
// two-level interrupt controller with eleven sources, one of them the watchdog
// assumes: requests, core strobes and bus come from logic on sys_clk_i;
// the core returns irq_ack_i when it pushes the pc and jumps to vector_o
//
// Summary of operation
// - priority byte: bit per source, 1 is high, bit 7 reserved
// - secondary bits 6,5,4 set interval, supply, serial priority
// - secondary bits 2,1,0 enable interval, supply, serial interrupts
// - secondary register at A9H, resets to A0H, byte access only
// - high request preempts a running low-level routine
// - simultaneous different levels: high level vectored first
// - no same-level request accepted while that level is in service
// - equal-level ties resolved by fixed polling order
// - accepting pushes pc and loads the source vector
// - watchdog timeout may raise an interrupt instead of reset
// - watchdog always high level and ignores global enable
// - zero watchdog timeout setting gives no watchdog interrupt
// - enable byte: global bit 7, bits 6..0 per source
// - enable at A8H, priority at B8H, both reset 00H, bit addressable
`timescale 1ns/10ps
module tlic_top (
	input  wire logic                      sys_clk_i,
	input  wire logic                      rstn_i,
	input  wire logic                      clk_en_i,
	input  wire logic [7:0]                addr_i,
	input  wire logic [7:0]                wdata_i,
	input  wire logic                      wr_i,
	input  wire logic                      rd_i,
	input  wire logic                      bit_wr_i,
	input  wire logic [2:0]                bit_sel_i,
	input  wire logic                      bit_val_i,
	output logic      [7:0]                rdata_o,
	input  wire logic [tlic_pkg::NSRC-1:0] src_req_i,
	input  wire logic                      wdt_timeout_i,
	input  wire logic                      wdt_irq_mode_i,
	input  wire logic [3:0]                wdt_period_i,
	output logic                           irq_req_o,
	output logic                           irq_hi_o,
	output logic      [15:0]               vector_o,
	input  wire logic                      irq_ack_i,
	input  wire logic                      reti_i,
	output logic      [tlic_pkg::NSRC-1:0] taken_o,
	output logic                           wdt_reset_o,
	output logic                           irq_o
);

	localparam int N = tlic_pkg::NSRC;

	// ==========================================================
	// helpers
	function automatic logic [7:0] byte_merge(input logic [7:0] old,
		input logic [7:0] wd, input logic [7:0] m);
		return (old & ~m) | (wd & m);
	endfunction

	function automatic logic [7:0] bit_merge(input logic [7:0] old,
		input logic [2:0] sel, input logic val);
		logic [7:0] r;
		r = old;
		r[sel] = val;
		return r;
	endfunction

	// ==========================================================
	// state
	logic [7:0]          ie_reg;
	logic [7:0]          ip_reg;
	logic [7:0]          secondary_enable_priority_reg;
	logic [3:0]          stat_reg;
	logic [3:0]          mask_reg;
	tlic_pkg::tlic_svc_e svc_reg;
	tlic_pkg::tlic_svc_e svc_next;
	logic                pend_reg;
	logic                pend_hi_reg;
	logic [3:0]          pend_idx_reg;
	logic [15:0]         vector_reg;
	logic [N-1:0]        taken_reg;
	logic                wdt_flag_reg;
	logic                wdt_rst_reg;
	logic [7:0]          rdata_reg;

	tlic_pick_if pk ();
	tlic_pick u_pick (
		.port (pk)
	);

	// ==========================================================
	// register decode
	wire hit_ie    = addr_i == tlic_pkg::ADDR_IE;
	wire hit_ip    = addr_i == tlic_pkg::ADDR_IP;
	wire hit_secondary_enable_priority = addr_i == tlic_pkg::ADDR_SECONDARY_ENABLE_PRIORITY;
	wire hit_stat  = addr_i == tlic_pkg::ADDR_STAT;
	wire hit_mask  = addr_i == tlic_pkg::ADDR_MASK;
	wire hit_svc   = addr_i == tlic_pkg::ADDR_SVC;

	wire [7:0] ie_next = (wr_i && hit_ie) ? wdata_i :
		(bit_wr_i && hit_ie) ? bit_merge(ie_reg, bit_sel_i, bit_val_i) :
		ie_reg;
	wire [7:0] ip_next = (wr_i && hit_ip) ?
		byte_merge(ip_reg, wdata_i, tlic_pkg::WMASK_IP) :
		(bit_wr_i && hit_ip) ? byte_merge(ip_reg,
		bit_merge(ip_reg, bit_sel_i, bit_val_i), tlic_pkg::WMASK_IP) :
		ip_reg;
	// bit writes never reach the secondary byte; bit 3 is held at zero
	wire [7:0] secondary_enable_priority_next = (wr_i && hit_secondary_enable_priority) ?
		byte_merge(secondary_enable_priority_reg, wdata_i, tlic_pkg::WMASK_IE2) :
		secondary_enable_priority_reg;
	wire [3:0] mask_next = (wr_i && hit_mask) ? wdata_i[3:0] : mask_reg;

	// ==========================================================
	// per-source enable, level and gating, polling order
	wire ie_glob = ie_reg[tlic_pkg::IE_GLOBAL];
	wire [N-1:0] src_en = {secondary_enable_priority_reg[tlic_pkg::E2_TIC_EN],
		ie_reg[tlic_pkg::IE_T2], ie_reg[tlic_pkg::IE_UART],
		secondary_enable_priority_reg[tlic_pkg::E2_SPI_EN], ie_reg[tlic_pkg::IE_T1],
		ie_reg[tlic_pkg::IE_EXT1], ie_reg[tlic_pkg::IE_T0],
		ie_reg[tlic_pkg::IE_ADC], ie_reg[tlic_pkg::IE_EXT0], 1'b1,
		secondary_enable_priority_reg[tlic_pkg::E2_PSM_EN]};
	wire [N-1:0] src_pri = {secondary_enable_priority_reg[tlic_pkg::E2_TIC_PRI],
		ip_reg[tlic_pkg::IE_T2], ip_reg[tlic_pkg::IE_UART],
		secondary_enable_priority_reg[tlic_pkg::E2_SPI_PRI], ip_reg[tlic_pkg::IE_T1],
		ip_reg[tlic_pkg::IE_EXT1], ip_reg[tlic_pkg::IE_T0],
		ip_reg[tlic_pkg::IE_ADC], ip_reg[tlic_pkg::IE_EXT0], 1'b1,
		secondary_enable_priority_reg[tlic_pkg::E2_PSM_PRI]};
	// the watchdog slot ignores the global enable so a timeout is answered
	wire [N-1:0] gate = {{(N - 2){ie_glob}}, 1'b1, ie_glob};
	wire [N-1:0] req_vec = {src_req_i[N-1:2], wdt_flag_reg, src_req_i[0]};
	wire [N-1:0] elig = req_vec & src_en & gate;

	wire allow_hi = (svc_reg == tlic_pkg::SVC_NONE) ||
		(svc_reg == tlic_pkg::SVC_LO);
	wire allow_lo = svc_reg == tlic_pkg::SVC_NONE;
	assign pk.cand_hi = allow_hi ? (elig & src_pri) : {N{1'b0}};
	assign pk.cand_lo = allow_lo ? (elig & ~src_pri) : {N{1'b0}};
	wire [N-1:0] cand_win = pk.hi ? pk.cand_hi : pk.cand_lo;

	// ==========================================================
	// acceptance; the offer is withdrawn the cycle after an ack so the
	// same source is not taken twice before its flag clears
	wire accept = irq_ack_i && pend_reg;
	wire pend_next = pk.found && !accept;
	// hold the vector on the accept edge so it names what the core took
	wire [15:0] vector_next = (pk.found && !accept) ?
		tlic_pkg::VEC[pk.idx] : vector_reg;
	wire [N-1:0] taken_next = accept ? N'(N'(1) << pend_idx_reg) :
		{N{1'b0}};

	always_comb begin
		svc_next = svc_reg;
		case (svc_reg)
			tlic_pkg::SVC_NONE: begin
				if (accept) begin
					svc_next = pend_hi_reg ? tlic_pkg::SVC_HI
					                       : tlic_pkg::SVC_LO;
				end
			end
			tlic_pkg::SVC_LO: begin
				if (accept) begin
					svc_next = reti_i ? tlic_pkg::SVC_HI
					                  : tlic_pkg::SVC_LO_HI;
				end else if (reti_i) begin
					svc_next = tlic_pkg::SVC_NONE;
				end
			end
			tlic_pkg::SVC_HI: begin
				if (reti_i) begin
					svc_next = tlic_pkg::SVC_NONE;
				end
			end
			tlic_pkg::SVC_LO_HI: begin
				if (reti_i) begin
					svc_next = tlic_pkg::SVC_LO;
				end
			end
			default: begin
				svc_next = tlic_pkg::SVC_NONE;
			end
		endcase
	end

	// ==========================================================
	// watchdog source
	wire wdt_arm = wdt_timeout_i && wdt_irq_mode_i &&
		(wdt_period_i != 4'h0);
	wire wdt_taken = accept && (pend_idx_reg == tlic_pkg::SRC_WDT);
	wire wdt_flag_next = wdt_arm || (wdt_flag_reg && !wdt_taken);
	wire wdt_rst_next = wdt_timeout_i && !wdt_irq_mode_i;

	// ==========================================================
	// event status, set wins over a write-one clear
	wire [3:0] ev = {wdt_rst_next, wdt_arm,
		accept && pend_hi_reg && (svc_reg == tlic_pkg::SVC_LO), accept};
	wire [3:0] st_clr = (wr_i && hit_stat) ? wdata_i[3:0] : 4'h0;
	wire [3:0] stat_next = ev | (stat_reg & ~st_clr);

	wire [7:0] rd_mux = hit_ie ? ie_reg : hit_ip ? ip_reg :
		hit_secondary_enable_priority ? secondary_enable_priority_reg : hit_stat ? {4'h0, stat_reg} :
		hit_mask ? {4'h0, mask_reg} :
		hit_svc ? {svc_reg, pend_idx_reg} : 8'h00;
	wire [7:0] rdata_next = rd_i ? rd_mux : 8'h00;

	// ==========================================================
	// flip-flops
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ie_reg    <= tlic_pkg::RST_IE;
			ip_reg    <= tlic_pkg::RST_IP;
			secondary_enable_priority_reg <= tlic_pkg::RST_SECONDARY_ENABLE_PRIORITY;
			stat_reg  <= tlic_pkg::RST_STAT;
			mask_reg  <= tlic_pkg::RST_MASK;
			rdata_reg <= 8'h00;
		end else if (clk_en_i) begin
			ie_reg    <= ie_next;
			ip_reg    <= ip_next;
			secondary_enable_priority_reg <= secondary_enable_priority_next;
			stat_reg  <= stat_next;
			mask_reg  <= mask_next;
			rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			svc_reg      <= tlic_pkg::SVC_NONE;
			pend_reg     <= 1'b0;
			pend_hi_reg  <= 1'b0;
			pend_idx_reg <= 4'h0;
			vector_reg   <= 16'h0000;
			taken_reg    <= {N{1'b0}};
			wdt_flag_reg <= 1'b0;
			wdt_rst_reg  <= 1'b0;
		end else if (clk_en_i) begin
			svc_reg      <= svc_next;
			pend_reg     <= pend_next;
			pend_hi_reg  <= pk.hi;
			pend_idx_reg <= pk.idx;
			vector_reg   <= vector_next;
			taken_reg    <= taken_next;
			wdt_flag_reg <= wdt_flag_next;
			wdt_rst_reg  <= wdt_rst_next;
		end
	end

	assign rdata_o     = rdata_reg;
	assign irq_req_o   = pend_reg;
	assign irq_hi_o    = pend_hi_reg;
	assign vector_o    = vector_reg;
	assign taken_o     = taken_reg;
	assign wdt_reset_o = wdt_rst_reg;
	assign irq_o       = |(stat_reg & mask_reg);

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	a_high_preempts_low: assert property (
		clk_en_i && accept && pend_hi_reg && !reti_i &&
		svc_reg == tlic_pkg::SVC_LO |=> svc_reg == tlic_pkg::SVC_LO_HI)
		else $error("high request did not preempt low routine");
	a_high_level_busy: assert property (
		svc_reg == tlic_pkg::SVC_HI || svc_reg == tlic_pkg::SVC_LO_HI
		|-> pk.cand_hi == {N{1'b0}})
		else $error("high request offered while high in service");
	a_low_level_busy: assert property (
		clk_en_i && svc_reg != tlic_pkg::SVC_NONE && !accept
		|=> !(pend_reg && !pend_hi_reg))
		else $error("low request offered while a level in service");
	a_high_first: assert property (
		clk_en_i && (pk.cand_hi != {N{1'b0}}) && !accept
		|=> pend_reg && pend_hi_reg)
		else $error("low request chosen over a high one");
	a_poll_order: assert property (
		clk_en_i && pk.found && !accept
		|=> ($past(cand_win) & N'(N'(N'(1) << pend_idx_reg) - N'(1)))
		== {N{1'b0}})
		else $error("later source won over an earlier one");
	a_vector_taken: assert property (
		clk_en_i && accept |=> taken_o[$past(pend_idx_reg)] &&
		vector_o == tlic_pkg::VEC[$past(pend_idx_reg)] ##1
		taken_o == {N{1'b0}})
		else $error("accepted source not vectored or not released");
	a_wdt_irq_mode: assert property (
		clk_en_i && wdt_arm |=> wdt_flag_reg && !wdt_reset_o)
		else $error("watchdog interrupt not raised");
	a_wdt_no_global: assert property (
		clk_en_i && wdt_flag_reg && !accept &&
		svc_reg == tlic_pkg::SVC_NONE |=> pend_reg && pend_hi_reg)
		else $error("watchdog not offered at high level");
	a_wdt_zero_period: assert property (
		clk_en_i && wdt_period_i == 4'h0 && !wdt_flag_reg
		|=> !wdt_flag_reg)
		else $error("watchdog raised with zero timeout");
	a_global_gate: assert property (
		clk_en_i && !ie_glob && pk.found && !accept
		|=> pend_idx_reg == tlic_pkg::SRC_WDT)
		else $error("source offered with global enable clear");
	a_sec_byte_only: assert property (
		clk_en_i && bit_wr_i && !wr_i && hit_secondary_enable_priority |=> $stable(secondary_enable_priority_reg))
		else $error("bit write changed the secondary register");
	a_reti_release: assert property (
		clk_en_i && reti_i && !accept &&
		svc_reg == tlic_pkg::SVC_LO_HI |=> svc_reg == tlic_pkg::SVC_LO)
		else $error("return did not release the high level");
	a_taken_onehot: assert property (
		$onehot0(taken_o))
		else $error("more than one source taken at once");
	a_enable_freeze: assert property (
		!clk_en_i |=> $stable(svc_reg) && $stable(ie_reg) &&
		$stable(stat_reg) && $stable(rdata_reg))
		else $error("state moved while the clock enable was low");

	c_preempt: cover property (clk_en_i && ev[1]);
	c_wdt_no_global: cover property (wdt_taken && !ie_glob);
	c_both_levels: cover property (|pk.cand_hi && |pk.cand_lo);
	c_nested_return: cover property (
		svc_reg == tlic_pkg::SVC_LO_HI ##1 svc_reg == tlic_pkg::SVC_LO);
	c_freeze: cover property (!clk_en_i && wr_i);

endmodule

// [verification/tlic_core_model.sv]
// partner model: the core that takes vectors, plus the peripherals' flags
// assumes: same clock as the controller; the bench pulses set_req_i and
// chooses whether and how slowly the core answers an offered request
`timescale 1ns/10ps
module tlic_core_model (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        auto_ack_i,
	input  wire logic [3:0]  delay_i,
	input  wire logic [10:0] set_req_i,
	input  wire logic [10:0] taken_i,
	input  wire logic        irq_req_i,
	input  wire logic        irq_hi_i,
	input  wire logic [15:0] vector_i,
	output logic             irq_ack_o,
	output logic      [10:0] src_req_o,
	output logic      [15:0] last_vec_o,
	output logic             last_hi_o,
	output logic             acked_o
);
	logic [3:0] wait_cnt;

	// ==========================================================
	// flags and core answer
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_ack_o  <= 1'b0;
			src_req_o  <= 11'h000;
			last_vec_o <= 16'h0000;
			last_hi_o  <= 1'b0;
			acked_o    <= 1'b0;
			wait_cnt   <= 4'h0;
		end else begin
			// a flag stays up until the controller reports it taken
			src_req_o <= (src_req_o & ~taken_i) | set_req_i;
			acked_o   <= 1'b0;
			if (irq_ack_o) begin
				// ack counts only if the offer still stood at this edge
				irq_ack_o  <= 1'b0;
				acked_o    <= irq_req_i;
				last_vec_o <= vector_i;
				last_hi_o  <= irq_hi_i;
				wait_cnt   <= 4'h0;
			end else if (auto_ack_i && irq_req_i) begin
				if (wait_cnt >= delay_i) begin
					irq_ack_o <= 1'b1;
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end else begin
				wait_cnt <= 4'h0;
			end
		end
	end
endmodule

// [verification/tlic_top_bench.sv]
// self-checking bench for the two-level interrupt controller
// assumes: tlic_core_model stands in for the core and the peripherals
`timescale 1ns/10ps
`define chk(name, exp, got) begin tests_run++; if ((got) !== (exp)) \
	begin fails++; $display("[ERR] %s expected %0h seen %0h", \
	name, exp, got); end end
module tlic_top_bench;
	logic        sys_clk;
	logic        rstn     = 1'b0;
	logic        ce       = 1'b1;
	logic [7:0]  addr     = 8'h00;
	logic [7:0]  wdata    = 8'h00;
	logic        wr       = 1'b0;
	logic        rd       = 1'b0;
	logic        bit_wr   = 1'b0;
	logic [2:0]  bit_sel  = 3'h0;
	logic        bit_val  = 1'b0;
	logic        wdt_to   = 1'b0;
	logic        wdt_mode = 1'b0;
	logic [3:0]  wdt_per  = 4'h0;
	logic        reti     = 1'b0;
	logic        auto_ack = 1'b0;
	logic [3:0]  delay    = 4'h0;
	logic [10:0] set_req  = 11'h000;
	logic [7:0]  rdata;
	logic        irq_req;
	logic        irq_hi;
	logic [15:0] vector;
	logic [10:0] taken;
	logic        wdt_rst;
	logic        irq;
	logic        ack;
	logic [10:0] src_req;
	logic [15:0] last_vec;
	logic        last_hi;
	logic        acked;
	int          fails     = 0;
	int          tests_run = 0;
	// poll order of the low-level sources and their vectors
	logic [3:0]  ord [10] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
		4'h8, 4'h9, 4'hA};
	logic [15:0] vec [10] = '{16'h0043, 16'h0003, 16'h0033, 16'h000B,
		16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	tlic_top dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .clk_en_i(ce),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.bit_wr_i(bit_wr), .bit_sel_i(bit_sel), .bit_val_i(bit_val),
		.rdata_o(rdata), .src_req_i(src_req), .wdt_timeout_i(wdt_to),
		.wdt_irq_mode_i(wdt_mode), .wdt_period_i(wdt_per),
		.irq_req_o(irq_req), .irq_hi_o(irq_hi), .vector_o(vector),
		.irq_ack_i(ack), .reti_i(reti), .taken_o(taken),
		.wdt_reset_o(wdt_rst), .irq_o(irq));

	tlic_core_model core (.clk_i(sys_clk), .rstn_i(rstn),
		.auto_ack_i(auto_ack), .delay_i(delay), .set_req_i(set_req),
		.taken_i(taken), .irq_req_i(irq_req), .irq_hi_i(irq_hi),
		.vector_i(vector), .irq_ack_o(ack), .src_req_o(src_req),
		.last_vec_o(last_vec), .last_hi_o(last_hi), .acked_o(acked));

	// ==========================================================
	// bus and core tasks
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge sys_clk);
		wr    <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge sys_clk);
		rd   <= 1'b0;
		#1;
		`chk("rdata_o", exp, rdata)
	endtask

	task automatic bit_reg(input logic [7:0] a, input logic [2:0] s,
		input logic v);
		@(posedge sys_clk);
		addr    <= a;
		bit_sel <= s;
		bit_val <= v;
		bit_wr  <= 1'b1;
		@(posedge sys_clk);
		bit_wr  <= 1'b0;
	endtask

	task automatic raise(input logic [10:0] m);
		@(posedge sys_clk);
		set_req <= m;
		@(posedge sys_clk);
		set_req <= 11'h000;
	endtask

	task automatic reti_pulse;
		@(posedge sys_clk);
		reti <= 1'b1;
		@(posedge sys_clk);
		reti <= 1'b0;
	endtask

	task automatic quiet(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			#1;
			`chk("irq_req_o", 1'b0, irq_req)
		end
	endtask

	// bounded waits: running out counts as a mismatch and ends the run
	task automatic wait_req(input logic [15:0] v, input logic hi);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (irq_req !== 1'b1 && n < 60);
		`chk("irq_req_o", 1'b1, irq_req)
		if (irq_req !== 1'b1) finish_test;
		`chk("vector_o", v, vector)
		`chk("irq_hi_o", hi, irq_hi)
	endtask

	task automatic wait_ack(input logic [3:0] idx, input logic [15:0] v,
		input logic hi);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (acked !== 1'b1 && n < 60);
		`chk("acked", 1'b1, acked)
		if (acked !== 1'b1) finish_test;
		`chk("vector_o", v, last_vec)
		`chk("irq_hi_o", hi, last_hi)
		`chk("taken_o", 11'h001 << idx, taken)
	endtask

	task automatic wdt_pulse(input logic mode, input logic [3:0] per);
		@(posedge sys_clk);
		wdt_mode <= mode;
		wdt_per  <= per;
		wdt_to   <= 1'b1;
		@(posedge sys_clk);
		wdt_to   <= 1'b0;
		#1;
		`chk("wdt_reset_o", ~mode, wdt_rst)
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		rd_reg(8'hA8, 8'h00);
		rd_reg(8'hB8, 8'h00);
		rd_reg(8'hA9, 8'hA0);
		rd_reg(8'hE8, 8'h00);
		rd_reg(8'hE9, 8'h00);
		rd_reg(8'h10, 8'h00);
		wr_reg(8'hB8, 8'hFF);
		rd_reg(8'hB8, 8'h7F);
		wr_reg(8'hA9, 8'hFF);
		rd_reg(8'hA9, 8'hF7);
		bit_reg(8'hA9, 3'h6, 1'b0);
		rd_reg(8'hA9, 8'hF7);
		wr_reg(8'hA9, 8'h87);
		rd_reg(8'hA9, 8'h87);
		wr_reg(8'hB8, 8'h00);
		bit_reg(8'hB8, 3'h3, 1'b1);
		rd_reg(8'hB8, 8'h08);
		auto_ack <= 1'b1;
		wr_reg(8'hA8, 8'h01);
		raise(11'h004);
		quiet(6);
		wr_reg(8'hA8, 8'h80);
		quiet(6);
		bit_reg(8'hA8, 3'h0, 1'b1);
		wait_ack(4'h2, 16'h0003, 1'b0);
		reti_pulse;
		wr_reg(8'hA8, 8'hFF);
		auto_ack <= 1'b0;
		raise(11'h044);
		wait_req(16'h001B, 1'b1);
		auto_ack <= 1'b1;
		wait_ack(4'h6, 16'h001B, 1'b1);
		quiet(5);
		reti_pulse;
		wait_ack(4'h2, 16'h0003, 1'b0);
		raise(11'h010);
		quiet(6);
		raise(11'h040);
		wait_ack(4'h6, 16'h001B, 1'b1);
		rd_reg(8'hEA, 8'h80);
		reti_pulse;
		quiet(5);
		reti_pulse;
		wait_ack(4'h4, 16'h000B, 1'b0);
		reti_pulse;
		bit_reg(8'hB8, 3'h3, 1'b0);
		raise(11'h7FD);
		for (int k = 0; k < 10; k++) begin
			delay <= 4'(k % 4);
			wait_ack(ord[k], vec[k], 1'b0);
			reti_pulse;
		end
		wr_reg(8'hA9, 8'hC7);
		raise(11'h480);
		wait_ack(4'hA, 16'h0053, 1'b1);
		reti_pulse;
		wait_ack(4'h7, 16'h003B, 1'b0);
		reti_pulse;
		wr_reg(8'hA8, 8'h00);
		// a write strobe while the clock enable is low must be ignored
		ce <= 1'b0;
		wr_reg(8'hE9, 8'h0F);
		ce <= 1'b1;
		rd_reg(8'hE9, 8'h00);
		wdt_pulse(1'b1, 4'h0);
		quiet(6);
		wdt_pulse(1'b1, 4'h3);
		wait_ack(4'h1, 16'h005B, 1'b1);
		reti_pulse;
		wdt_pulse(1'b0, 4'h3);
		quiet(4);
		rd_reg(8'hE8, 8'h0F);
		wr_reg(8'hE9, 8'h02);
		#1;
		`chk("irq_o", 1'b1, irq)
		wr_reg(8'hE8, 8'h02);
		#1;
		`chk("irq_o", 1'b0, irq)
		rd_reg(8'hE8, 8'h0D);
		finish_test;
	end
endmodule
